// File: dss_defines.svh
// constants for the drive disable stop sequencer
`ifndef DSS_DEFINES_SVH
`define DSS_DEFINES_SVH
// ==========================================
// register offsets
`define DSS_ADDR_W 8
`define DSS_OFS_CTRL 8'h00
`define DSS_OFS_SPEED 8'h04
`define DSS_OFS_HOLD 8'h08
`define DSS_OFS_DECEL 8'h0c
`define DSS_OFS_IMAX 8'h10
`define DSS_OFS_STATUS 8'h14
`define DSS_OFS_VCMD 8'h18
// ==========================================
// control fields
`define DSS_CTRL_SEL_LSB 0
`define DSS_CTRL_OPM_LSB 4
`define DSS_CTRL_FUNC_LSB 8
`define DSS_CTRL_INV_BIT 12
`define DSS_SEL_W 3
`define DSS_OPM_W 3
`define DSS_FUNC_W 4
`define DSS_FUNC_BRAKE 4'h2
`define DSS_OPM_CUR_A 3'h2
`define DSS_OPM_CUR_B 3'h3
// ==========================================
// reset values
`define DSS_RST_SPEED 16'h0064
`define DSS_RST_HOLD 16'h0014
`define DSS_RST_DECEL 16'h0010
`define DSS_RST_IMAX 16'h0100
// ==========================================
// timing
`define DSS_CLK_HZ 25000000
`define DSS_BG_PERIOD_US 500
`define DSS_BG_CYCLES (`DSS_CLK_HZ / 1000000 * `DSS_BG_PERIOD_US)
`define DSS_QUAL_MS 50
`define DSS_QUAL_TICKS 8'((`DSS_QUAL_MS * 1000) / `DSS_BG_PERIOD_US)
`define DSS_ENABLE_MAX_US_X10 15
`define DSS_RAMP_GRACE_TICKS 8'h40
`endif

// File: dss_pkg.sv
// types for the drive disable stop sequencer
package dss_pkg;
  typedef enum logic [3:0] {
    DSS_OFF = 4'b0001,
    DSS_ON = 4'b0010,
    DSS_RAMP = 4'b0100,
    DSS_HOLD = 4'b1000
  } dss_state_t;
  typedef enum logic [2:0] {
    DSS_SEL_COAST = 3'h0,
    DSS_SEL_DB_FAULT = 3'h1,
    DSS_SEL_DB_ANY = 3'h2,
    DSS_SEL_AD = 3'h3,
    DSS_SEL_AD_DB_FAULT = 3'h4,
    DSS_SEL_AD_DB_ANY = 3'h5
  } dss_sel_t;
endpackage

// File: dss_plant.sv
// motor and load model facing the disable stop sequencer
`timescale 1ns/1ps
module dss_plant (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic power_en_i,
  input wire logic stuck_i,
  input wire logic signed [15:0] vel_cmd_i,
  output logic signed [15:0] vel_act_o
);
  // powered: follow the command; unpowered: coast down slowly
  // stuck: the load refuses to slow, used only by the ramp timeout test
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      vel_act_o <= 16'sh0000;
    end else if (!stuck_i) begin
      if (power_en_i) begin
        vel_act_o <= vel_cmd_i;
      end else if (vel_act_o != 16'sh0000) begin
        vel_act_o <= vel_act_o - ((vel_act_o > 16'sh0000) ? 16'sh0001 : -16'sh0001);
      end
    end
  end
endmodule // dss_plant

// File: dss_top.sv
// drive disable stop sequencer with apb registers
`timescale 1ns/1ps
`include "dss_defines.svh"
module dss_top import dss_pkg::*; #(
  parameter int BG_CYCLES = `DSS_BG_CYCLES,
  parameter int VEL_W = 16
) (
  input wire logic MCLK_I,
  input wire logic SRST_I,
  input wire logic PSEL_I,
  input wire logic PENABLE_I,
  input wire logic PWRITE_I,
  input wire logic [`DSS_ADDR_W-1:0] PADDR_I,
  input wire logic [31:0] PWDATA_I,
  output logic [31:0] PRDATA_O,
  output logic PREADY_O,
  output logic PSLVERR_O,
  input wire logic EN_CMD_I,
  input wire logic DIS_CMD_I,
  input wire logic MOTION_VALID_I,
  input wire logic signed [VEL_W-1:0] MOTION_VEL_I,
  input wire logic signed [VEL_W-1:0] VEL_ACT_I,
  input wire logic FAULT_I,
  input wire logic FAULT_HW_I,
  input wire logic SAFE_TORQUE_OFF_FAULT_I,
  input wire logic FB_LOST_I,
  output logic signed [VEL_W-1:0] VEL_CMD_O,
  output logic POWER_EN_O,
  output logic BRAKE_REL_O,
  output logic DYN_BRAKE_O,
  output logic [VEL_W-1:0] BRAKE_I_LIM_O,
  output logic RAMPING_O
);
  generate
    if (BG_CYCLES < 2 || BG_CYCLES > 65535 || VEL_W < 8 || VEL_W > 16) begin : g_bad
      $error("dss_top: unsupported parameter value");
    end
  endgenerate

  function automatic logic [VEL_W-1:0] vabs(input logic signed [VEL_W-1:0] v);
    vabs = v[VEL_W-1] ? VEL_W'(-v) : VEL_W'(v);
  endfunction

  // ==========================================
  // registers
  dss_state_t state, next_state;
  logic [`DSS_SEL_W-1:0] sel;
  logic [`DSS_OPM_W-1:0] opmode;
  logic [`DSS_FUNC_W-1:0] out_func;
  logic invert;
  logic [VEL_W-1:0] speed_thr, hold_time, decel, imax;
  logic signed [VEL_W-1:0] vel_cmd, next_vel;
  logic rel, next_rel, dyn, next_dyn, cause_fault, next_cause;
  logic [15:0] bg_cnt;
  logic tick;
  logic [7:0] qual_cnt, grace_cnt;
  logic [VEL_W-1:0] hold_cnt, tmo_vel;
  logic sto_m, sto_s, fbl_m, fbl_s;

  // ==========================================
  // pin synchronisers and background tick
  always_ff @(posedge MCLK_I) begin
    if (SRST_I) begin
      sto_m <= 1'b0;
      sto_s <= 1'b0;
      fbl_m <= 1'b0;
      fbl_s <= 1'b0;
    end else begin
      sto_m <= SAFE_TORQUE_OFF_FAULT_I;
      sto_s <= sto_m;
      fbl_m <= FB_LOST_I;
      fbl_s <= fbl_m;
    end
  end

  wire bg_wrap = bg_cnt == 16'(BG_CYCLES - 1);
  always_ff @(posedge MCLK_I) begin
    if (SRST_I) begin
      bg_cnt <= 16'h0000;
      tick <= 1'b0;
    end else begin
      bg_cnt <= bg_wrap ? 16'h0000 : bg_cnt + 16'h0001;
      tick <= bg_wrap;
    end
  end

  // ==========================================
  // decision terms
  wire hw_fault = FAULT_HW_I | sto_s | fbl_s;
  wire any_fault = hw_fault | FAULT_I;
  wire cur_mode = opmode == `DSS_OPM_CUR_A || opmode == `DSS_OPM_CUR_B;
  wire ramp_sel = sel == DSS_SEL_AD || sel == DSS_SEL_AD_DB_FAULT || sel == DSS_SEL_AD_DB_ANY;
  wire ramp_ok = ramp_sel && !cur_mode;
  wire db_any = sel == DSS_SEL_DB_ANY || sel == DSS_SEL_AD_DB_ANY;
  wire db_fault = sel == DSS_SEL_DB_FAULT || sel == DSS_SEL_AD_DB_FAULT;
  wire slow = vabs(VEL_ACT_I) < speed_thr;
  wire qual_done = qual_cnt == `DSS_QUAL_TICKS;
  wire hold_gate = !cause_fault || slow;
  wire hold_done = hold_cnt >= hold_time;
  wire ramp_tmo = grace_cnt == `DSS_RAMP_GRACE_TICKS;
  wire [VEL_W-1:0] vmag = vabs(vel_cmd);
  wire signed [VEL_W-1:0] vel_step = (vmag <= decel) ? VEL_W'(0) :
    (vel_cmd[VEL_W-1] ? VEL_W'(vel_cmd + decel) : VEL_W'(vel_cmd - decel));

  // ==========================================
  // state machine
  always_comb begin
    next_state = state;
    next_cause = cause_fault;
    case (state)
      DSS_OFF: begin
        if (EN_CMD_I && !any_fault) begin
          next_state = DSS_ON;
          next_cause = 1'b0;
        end
      end
      DSS_ON: begin
        if (hw_fault) begin
          next_state = DSS_OFF;
          next_cause = 1'b1;
        end else if (FAULT_I) begin
          next_state = ramp_ok ? DSS_RAMP : DSS_OFF;
          next_cause = 1'b1;
        end else if (DIS_CMD_I) begin
          next_state = DSS_HOLD;
          next_cause = 1'b0;
        end
      end
      DSS_RAMP: begin
        if (hw_fault || DIS_CMD_I || ramp_tmo) begin
          next_state = DSS_OFF;
        end else if (qual_done) begin
          next_state = DSS_HOLD;
        end
      end
      DSS_HOLD: begin
        if (hw_fault || hold_done) begin
          next_state = DSS_OFF;
        end
      end
      default: begin
        next_state = DSS_OFF;
      end
    endcase
  end

  always_comb begin
    next_vel = VEL_W'(0);
    if (next_state == DSS_ON) begin
      next_vel = (state == DSS_ON && MOTION_VALID_I) ? MOTION_VEL_I : vel_cmd;
    end else if (next_state == DSS_RAMP) begin
      next_vel = (state == DSS_RAMP && tick) ? vel_step : vel_cmd;
    end
  end

  // release held through the ramp, dropped when the hold count starts
  assign next_rel = next_state == DSS_ON || next_state == DSS_RAMP;

  always_comb begin
    next_dyn = 1'b0;
    if (next_state == DSS_OFF) begin
      if (state != DSS_OFF) begin
        next_dyn = db_any || (next_cause && db_fault);
      end else begin
        next_dyn = dyn;
      end
    end
  end

  always_ff @(posedge MCLK_I) begin
    if (SRST_I) begin
      state <= DSS_OFF;
      cause_fault <= 1'b0;
      vel_cmd <= '0;
      rel <= 1'b0;
      dyn <= 1'b0;
    end else begin
      state <= next_state;
      cause_fault <= next_cause;
      vel_cmd <= next_vel;
      rel <= next_rel;
      dyn <= next_dyn;
    end
  end

  // ==========================================
  // stop qualification, hold and timeout counters
  always_ff @(posedge MCLK_I) begin
    if (SRST_I || state != DSS_RAMP) begin
      qual_cnt <= 8'h00;
      grace_cnt <= 8'h00;
    end else if (tick) begin
      qual_cnt <= slow ? qual_cnt + 8'h01 : 8'h00;
      // only ticks still above threshold eat the grace, so a qualifying stop is never cut short
      if (tmo_vel == '0 && !slow) begin
        grace_cnt <= grace_cnt + 8'h01;
      end
    end
  end

  always_ff @(posedge MCLK_I) begin
    if (SRST_I || state != DSS_HOLD) begin
      hold_cnt <= '0;
    end else if (tick) begin
      hold_cnt <= hold_gate ? hold_cnt + VEL_W'(1) : VEL_W'(0);
    end
  end

  // timeout budget: actual speed worn down by the stop rate each background tick
  always_ff @(posedge MCLK_I) begin
    if (SRST_I) begin
      tmo_vel <= '0;
    end else if (state == DSS_ON) begin
      tmo_vel <= vabs(VEL_ACT_I);
    end else if (state == DSS_RAMP && tick) begin
      tmo_vel <= (tmo_vel <= decel) ? VEL_W'(0) : VEL_W'(tmo_vel - decel);
    end
  end

  // ==========================================
  // outputs
  always_ff @(posedge MCLK_I) begin
    if (SRST_I) begin
      VEL_CMD_O <= '0;
      POWER_EN_O <= 1'b0;
      BRAKE_REL_O <= 1'b0;
      DYN_BRAKE_O <= 1'b0;
      BRAKE_I_LIM_O <= '0;
      RAMPING_O <= 1'b0;
    end else begin
      VEL_CMD_O <= next_vel;
      POWER_EN_O <= next_state != DSS_OFF;
      BRAKE_REL_O <= (out_func == `DSS_FUNC_BRAKE) & (next_rel ^ invert);
      DYN_BRAKE_O <= next_dyn;
      BRAKE_I_LIM_O <= next_dyn ? imax : VEL_W'(0);
      RAMPING_O <= next_state == DSS_RAMP;
    end
  end

  // ==========================================
  // apb slave
  wire hit_ctrl = PADDR_I == `DSS_OFS_CTRL;
  wire hit_speed = PADDR_I == `DSS_OFS_SPEED;
  wire hit_hold = PADDR_I == `DSS_OFS_HOLD;
  wire hit_decel = PADDR_I == `DSS_OFS_DECEL;
  wire hit_imax = PADDR_I == `DSS_OFS_IMAX;
  wire hit_stat = PADDR_I == `DSS_OFS_STATUS;
  wire hit_vcmd = PADDR_I == `DSS_OFS_VCMD;
  wire hit_rw = hit_ctrl | hit_speed | hit_hold | hit_decel | hit_imax;
  wire hit = hit_rw | hit_stat | hit_vcmd;
  wire acc = PSEL_I & PENABLE_I & ~PREADY_O;
  wire wr = PSEL_I & PENABLE_I & PREADY_O & PWRITE_I & hit_rw;
  wire [31:0] ctrl_rd = {19'h0, invert, out_func, 1'b0, opmode, 1'b0, sel};
  wire [31:0] stat_rd = {24'h0, cause_fault, dyn, POWER_EN_O, rel, state};
  wire [31:0] rd_val = hit_ctrl ? ctrl_rd :
    hit_speed ? 32'(speed_thr) :
    hit_hold ? 32'(hold_time) :
    hit_decel ? 32'(decel) :
    hit_imax ? 32'(imax) :
    hit_stat ? stat_rd :
    hit_vcmd ? 32'($unsigned(vel_cmd)) : 32'h0000_0000;

  always_ff @(posedge MCLK_I) begin
    if (SRST_I) begin
      PREADY_O <= 1'b0;
      PSLVERR_O <= 1'b0;
      PRDATA_O <= 32'h0000_0000;
    end else begin
      PREADY_O <= acc;
      PSLVERR_O <= acc & ~hit;
      PRDATA_O <= (acc & ~PWRITE_I) ? rd_val : 32'h0000_0000;
    end
  end

  always_ff @(posedge MCLK_I) begin
    if (SRST_I) begin
      sel <= 3'h0;
      opmode <= 3'h0;
      out_func <= 4'h0;
      invert <= 1'b0;
      speed_thr <= VEL_W'(`DSS_RST_SPEED);
      hold_time <= VEL_W'(`DSS_RST_HOLD);
      decel <= VEL_W'(`DSS_RST_DECEL);
      imax <= VEL_W'(`DSS_RST_IMAX);
    end else if (wr) begin
      if (hit_ctrl) begin
        sel <= PWDATA_I[`DSS_CTRL_SEL_LSB +: `DSS_SEL_W];
        opmode <= PWDATA_I[`DSS_CTRL_OPM_LSB +: `DSS_OPM_W];
        out_func <= PWDATA_I[`DSS_CTRL_FUNC_LSB +: `DSS_FUNC_W];
        invert <= PWDATA_I[`DSS_CTRL_INV_BIT];
      end else if (hit_speed) begin
        speed_thr <= PWDATA_I[VEL_W-1:0];
      end else if (hit_hold) begin
        hold_time <= PWDATA_I[VEL_W-1:0];
      end else if (hit_decel) begin
        decel <= PWDATA_I[VEL_W-1:0];
      end else begin
        imax <= PWDATA_I[VEL_W-1:0];
      end
    end
  end

  // ==========================================
  // assertions
  default clocking cb @(posedge MCLK_I); endclocking
  default disable iff (SRST_I);

  sequence s_on_soft_fault;
    state == DSS_ON && FAULT_I && !hw_fault;
  endsequence
  sequence s_enter_hold;
    state != DSS_HOLD ##1 state == DSS_HOLD;
  endsequence

  property p_coast;
    s_on_soft_fault and (sel == DSS_SEL_COAST) |=> state == DSS_OFF && !DYN_BRAKE_O && !RAMPING_O;
  endproperty
  a_coast: assert property (p_coast) else $error("coast select braked or ramped");
  property p_db_fault;
    s_on_soft_fault and (sel == DSS_SEL_DB_FAULT) |=> state == DSS_OFF && DYN_BRAKE_O;
  endproperty
  a_db_fault: assert property (p_db_fault) else $error("fault braking missing");
  property p_ramp_sel;
    s_on_soft_fault and (ramp_sel && !cur_mode) |=> state == DSS_RAMP && RAMPING_O;
  endproperty
  a_ramp_sel: assert property (p_ramp_sel) else $error("ramp not started on fault");
  property p_hw_fault;
    (state == DSS_ON || state == DSS_RAMP) && FAULT_HW_I |=> state == DSS_OFF && !POWER_EN_O;
  endproperty
  a_hw_fault: assert property (p_hw_fault) else $error("hardware fault did not disable");
  property p_qual;
    state == DSS_RAMP ##1 state == DSS_HOLD |-> $past(qual_cnt) == `DSS_QUAL_TICKS;
  endproperty
  a_qual: assert property (p_qual) else $error("hold entered before stop qualified");
  property p_cur_mode;
    s_on_soft_fault and cur_mode |=> state != DSS_RAMP;
  endproperty
  a_cur_mode: assert property (p_cur_mode) else $error("ramp in current mode");
  property p_ignore_motion;
    state == DSS_RAMP && next_state == DSS_RAMP && MOTION_VALID_I |=> vmag <= $past(vmag);
  endproperty
  a_ignore_motion: assert property (p_ignore_motion) else $error("motion taken during ramp");
  property p_abort;
    state == DSS_RAMP && DIS_CMD_I |=> state == DSS_OFF && !POWER_EN_O;
  endproperty
  a_abort: assert property (p_abort) else $error("second disable did not abort");
  property p_brake_hold;
    s_enter_hold |-> !rel && hold_cnt == '0;
  endproperty
  a_brake_hold: assert property (p_brake_hold) else $error("release held at hold start");
  property p_zero_cmd;
    state == DSS_ON && DIS_CMD_I && !any_fault |=> VEL_CMD_O == '0 && POWER_EN_O;
  endproperty
  a_zero_cmd: assert property (p_zero_cmd) else $error("command not zeroed at disable");
  property p_enable;
    state == DSS_OFF && EN_CMD_I && !any_fault |=> POWER_EN_O && rel;
  endproperty
  a_enable: assert property (p_enable) else $error("enable slow or release late");
  property p_sto;
    sto_s && state != DSS_OFF |=> !POWER_EN_O && !rel;
  endproperty
  a_sto: assert property (p_sto) else $error("safe torque off not immediate");
endmodule // dss_top

// File: testbench.sv
// self-checking bench for the drive disable stop sequencer
`timescale 1ns/1ps
`include "dss_defines.svh"
`define CHK(nm, e, g) begin cmp_count++; if ((g) !== (e)) begin bad_count++; \
  $display("[FAIL] %s expected %h seen %h", nm, e, g); end end
module testbench;
  localparam int BG = 8;
  logic clk, srst, psel, penable, pwrite, en_cmd, dis_cmd, mv, flt, flt_hw, safe_torque_off_fault, fbl, stuck;
  logic pready, pslverr, power_en, brake_rel, dyn_brake, ramping;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata;
  logic signed [15:0] mvel, vact, vel_cmd, v;
  logic [15:0] ilim;
  logic [32:0] notes[$];
  logic [32:0] note;
  int bad_count = 0;
  int cmp_count = 0;
  int n;
  int seed = 23;
  dss_top #(.BG_CYCLES(BG)) DUT (.MCLK_I(clk), .SRST_I(srst), .PSEL_I(psel), .PENABLE_I(penable),
    .PWRITE_I(pwrite), .PADDR_I(paddr), .PWDATA_I(pwdata), .PRDATA_O(prdata), .PREADY_O(pready),
    .PSLVERR_O(pslverr), .EN_CMD_I(en_cmd), .DIS_CMD_I(dis_cmd), .MOTION_VALID_I(mv),
    .MOTION_VEL_I(mvel), .VEL_ACT_I(vact), .FAULT_I(flt), .FAULT_HW_I(flt_hw),
    .SAFE_TORQUE_OFF_FAULT_I(safe_torque_off_fault), .FB_LOST_I(fbl), .VEL_CMD_O(vel_cmd), .POWER_EN_O(power_en),
    .BRAKE_REL_O(brake_rel), .DYN_BRAKE_O(dyn_brake), .BRAKE_I_LIM_O(ilim), .RAMPING_O(ramping));
  dss_plant plant (.clk_i(clk), .rst_i(srst), .power_en_i(power_en), .stuck_i(stuck),
    .vel_cmd_i(vel_cmd), .vel_act_o(vact));
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  // ==========================================
  // read monitor: oldest note against each read answer
  always @(posedge clk) begin
    if (pready === 1'b1 && pwrite === 1'b0) begin
      note = notes.pop_front();
      `CHK("read", note, {pslverr, prdata})
    end
  end
  // ==========================================
  // tasks
  task automatic print_verdict();
    $display("comparisons %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  task automatic timeout();
    bad_count++;
    $display("[FAIL] wait expected done seen timeout");
    print_verdict();
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int k;
    k = 0;
    psel <= 1'b1; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do begin @(posedge clk); k++; end while (pready !== 1'b1 && k < 50);
    if (k >= 50) timeout();
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic err);
    notes.push_back({err, e});
    apb(1'b0, a, 32'h0);
  endtask
  task automatic cfg(input int s, input int opm, input int inv);
    apb(1'b1, `DSS_OFS_CTRL, 32'(s) | (32'(opm) << 4) | 32'h200 | (32'(inv) << 12));
  endtask
  task automatic cmd(input int d);
    if (d == 0) en_cmd <= 1'b1; else dis_cmd <= 1'b1;
    @(posedge clk);
    en_cmd <= 1'b0;
    dis_cmd <= 1'b0;
    @(posedge clk);
  endtask
  task automatic motion(input logic signed [15:0] val);
    mv <= 1'b1;
    mvel <= val;
    @(posedge clk);
    mv <= 1'b0;
    @(posedge clk);
  endtask
  task automatic wt(input int w, input int lim, output int k);
    k = 0;
    while ((w ? ramping : power_en) === 1'b1 && k < lim) begin @(posedge clk); k++; end
    if (k >= lim) timeout();
  endtask
  task automatic done(input string nm);
    $display("test %s finished", nm);
  endtask
  initial begin
    repeat (100000) @(posedge clk);
    timeout();
  end
  // ==========================================
  // main sequence
  initial begin
    {psel, penable, pwrite, en_cmd, dis_cmd, mv, flt, flt_hw, safe_torque_off_fault, fbl, stuck} = '0;
    paddr = 8'h00; pwdata = 32'h0; mvel = 16'sh0000; srst = 1'b1;
    repeat (20) @(posedge clk);
    srst <= 1'b0;
    @(posedge clk);
    rd(`DSS_OFS_CTRL, 32'h0, 1'b0);
    rd(`DSS_OFS_SPEED, 32'h64, 1'b0);
    rd(`DSS_OFS_HOLD, 32'h14, 1'b0);
    rd(`DSS_OFS_DECEL, 32'h10, 1'b0);
    rd(`DSS_OFS_IMAX, 32'h100, 1'b0);
    rd(8'h1c, 32'h0, 1'b1);
    apb(1'b1, `DSS_OFS_HOLD, 32'h3);
    apb(1'b1, `DSS_OFS_IMAX, 32'h55);
    rd(`DSS_OFS_HOLD, 32'h3, 1'b0);
    done("registers");
    for (int s = 0; s < 6; s++) begin
      cfg(s, 0, 0);
      cmd(0);
      `CHK("en_power", 1'b1, power_en)
      `CHK("en_release", 1'b1, brake_rel)
      motion(16'sh0200);
      cmd(1);
      `CHK("dis_release", 1'b0, brake_rel)
      `CHK("dis_power", 1'b1, power_en)
      `CHK("dis_vel", 16'sh0000, vel_cmd)
      wt(0, 4000, n);
      `CHK("hold_time", 1'b1, n >= 2 * BG && n <= 4 * BG)
      `CHK("dyn_cmd", s == 2 || s == 5, dyn_brake)
      `CHK("ilim", (s == 2 || s == 5) ? 16'h0055 : 16'h0000, ilim)
    end
    done("command disable");
    for (int s = 0; s < 6; s++) begin
      cfg(s, 0, 0);
      cmd(0);
      motion(16'sh0200);
      flt <= 1'b1;
      repeat (2) @(posedge clk);
      `CHK("ramp_sel", s >= 3, ramping)
      `CHK("fault_off", s >= 3, power_en)
      if (s >= 3) begin
        motion(16'sh0300);
        `CHK("ignore_motion", 1'b1, vel_cmd <= 16'sh0200)
        wt(1, 2000, n);
        `CHK("ramp_zero", 16'sh0000, vel_cmd)
        `CHK("ramp_power", 1'b1, power_en)
        `CHK("hold_brake", 1'b0, brake_rel)
        `CHK("qualify", 1'b1, n >= 120 * BG)
      end
      wt(0, 4000, n);
      `CHK("dyn_fault", s != 0 && s != 3, dyn_brake)
      `CHK("coast_vel", 16'sh0000, vel_cmd)
      flt <= 1'b0;
      @(posedge clk);
    end
    rd(`DSS_OFS_STATUS, 32'hc1, 1'b0);
    done("fault disable");
    for (int m = 2; m < 4; m++) begin
      cfg(5, m, 0);
      cmd(0);
      flt <= 1'b1;
      repeat (2) @(posedge clk);
      `CHK("cur_ramp", 1'b0, ramping)
      `CHK("cur_power", 1'b0, power_en)
      flt <= 1'b0;
      @(posedge clk);
    end
    done("current mode");
    for (int k = 0; k < 4; k++) begin
      cfg(3, 0, 0);
      cmd(0);
      motion(16'sh0200);
      flt <= (k == 0); flt_hw <= (k == 1); safe_torque_off_fault <= (k == 2); fbl <= (k == 3);
      repeat (4) @(posedge clk);
      `CHK("abort_ramp", k == 0, ramping)
      if (k == 0) cmd(1);
      `CHK("abort_power", 1'b0, power_en)
      `CHK("abort_release", 1'b0, brake_rel)
      {flt, flt_hw, safe_torque_off_fault, fbl} <= 4'h0;
      repeat (4) @(posedge clk);
    end
    done("immediate stop");
    cfg(3, 0, 0);
    cmd(0);
    motion(16'sh0200);
    stuck <= 1'b1;
    flt <= 1'b1;
    wt(0, 4000, n);
    `CHK("ramp_timeout", 1'b1, n >= 93 * BG && n <= 99 * BG)
    stuck <= 1'b0;
    flt <= 1'b0;
    done("ramp timeout");
    cfg(0, 0, 1);
    @(posedge clk);
    `CHK("inv_off", 1'b1, brake_rel)
    cmd(0);
    `CHK("inv_on", 1'b0, brake_rel)
    for (int i = 0; i < 6; i++) begin
      v = 16'($random(seed));
      motion(v);
      rd(`DSS_OFS_VCMD, {16'h0, v}, 1'b0);
    end
    cmd(1);
    wt(0, 4000, n);
    apb(1'b1, `DSS_OFS_CTRL, 32'h1000);
    @(posedge clk);
    `CHK("no_brake_func", 1'b0, brake_rel)
    done("polarity and motion");
    print_verdict();
  end
endmodule // testbench
